// [rtl/ccq_dual_rail.v]
// Output register that drives each bit together with its registered inverse
`timescale 1ns/1ns
module ccq_dual_rail #(
    parameter WIDTH = 12,
    parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'h0}}
) (
    input wire clock,
    input wire reset,
    input wire [WIDTH-1:0] next_value,
    output reg [WIDTH-1:0] value,
    output reg [WIDTH-1:0] value_inverse
);

    // Two separate flops so a stuck bit on one rail shows up as a mismatch
    always @(posedge clock) begin
        if (reset) begin
            value <= RESET_VALUE;
            value_inverse <= ~RESET_VALUE;
        end else begin
            value <= next_value;
            value_inverse <= ~next_value;
        end
    end

endmodule // ccq_dual_rail

// [rtl/ccq_map.vh]
// Constants for the cluster clock quiesce handshake block
`ifndef CCQ_MAP_VH
`define CCQ_MAP_VH

// Channel positions inside the packed per-domain vectors
`define CCQ_CH_SHARED 0
`define CCQ_CH_DEBUG 1
`define CCQ_CH_TRACE 2
`define CCQ_CH_INTC 3
`define CCQ_NUM_CH 4

// One-hot channel states
`define CCQ_ST_RUN 3'h1
`define CCQ_ST_STOPPED 3'h2
`define CCQ_ST_REFUSED 3'h4

// Field positions inside the packed response vector
`define CCQ_F_NEEDED 0
`define CCQ_F_ACCEPT 4
`define CCQ_F_REFUSE 8
`define CCQ_RESP_W 12

// Reset values: no clock needed, no accept (high), refuse idle per polarity
`define CCQ_RST_NEEDED 4'h0
`define CCQ_RST_ACCEPT_LOW 4'hF
// Trace refuse output idles high because it is active low
`define CCQ_REFUSE_LOW_MASK 4'h4

`endif

// [rtl/ccq_top.v]
// Four-domain clock-gating quiesce handshake, cluster side
`timescale 1ns/1ns
`include "ccq_map.vh"
module ccq_top #(
    parameter [`CCQ_NUM_CH-1:0] REFUSE_LOW_MASK = `CCQ_REFUSE_LOW_MASK
) (
    input wire clock,
    input wire reset,
    // Cluster-side busy indications, one per domain
    input wire shared_clk_busy,
    input wire debug_clk_busy,
    input wire trace_clk_busy,
    input wire intc_clk_busy,
    // Shared cluster clock channel
    output wire shared_clk_needed,
    output wire shared_clk_needed_inverse,
    input wire shared_clk_gate_request_low,
    input wire shared_clk_request_inverse,
    output wire shared_clk_gate_accept_low,
    output wire shared_clk_accept_inverse,
    output wire shared_clk_gate_refuse,
    output wire shared_clk_refuse_inverse,
    // Debug peripheral clock channel
    output wire debug_clk_needed,
    output wire debug_clk_needed_inverse,
    input wire debug_clk_gate_request_low,
    input wire debug_clk_request_inverse,
    output wire debug_clk_gate_accept_low,
    output wire debug_clk_accept_inverse,
    output wire debug_clk_gate_refuse,
    output wire debug_clk_refuse_inverse,
    // Trace bus clock channel
    output wire trace_clk_needed,
    output wire trace_clk_needed_inverse,
    input wire trace_clk_gate_request_low,
    input wire trace_clk_request_inverse,
    output wire trace_clk_gate_accept_low,
    output wire trace_clk_accept_inverse,
    output wire trace_clk_gate_refuse,
    output wire trace_clk_refuse_inverse,
    // Interrupt controller clock channel
    output wire intc_clk_needed,
    output wire intc_clk_needed_inverse,
    input wire intc_clk_gate_request_low,
    input wire intc_clk_request_inverse,
    output wire intc_clk_gate_accept_low,
    output wire intc_clk_accept_inverse,
    output wire intc_clk_gate_refuse,
    output wire intc_clk_refuse_inverse,
    // Request pair mismatch, one per domain
    output wire shared_clk_check_fault,
    output wire debug_clk_check_fault,
    output wire trace_clk_check_fault,
    output wire intc_clk_check_fault
);

    // A request counts only while its inverse twin agrees with it
    function pair_ok;
        input level_low;
        input level_inverse;
        begin
            pair_ok = (level_inverse == ~level_low);
        end
    endfunction

    // One-hot state test; an illegal code matches nothing and reads as idle
    function in_state;
        input [2:0] state_code;
        input [2:0] wanted;
        begin
            in_state = (state_code == wanted);
        end
    endfunction

    // Applies the pin polarity of one domain to its refusal level
    function refuse_pin;
        input refusing;
        input active_low;
        begin
            refuse_pin = refusing ^ active_low;
        end
    endfunction

    wire [`CCQ_NUM_CH-1:0] busy;
    wire [`CCQ_NUM_CH-1:0] req_low;
    wire [`CCQ_NUM_CH-1:0] req_inverse;
    wire [`CCQ_RESP_W-1:0] next_resp;
    wire [`CCQ_RESP_W-1:0] resp;
    wire [`CCQ_RESP_W-1:0] resp_inverse;
    wire [`CCQ_NUM_CH-1:0] fault;

    assign busy = {intc_clk_busy, trace_clk_busy, debug_clk_busy, shared_clk_busy};
    assign req_low = {intc_clk_gate_request_low, trace_clk_gate_request_low,
                      debug_clk_gate_request_low, shared_clk_gate_request_low};
    assign req_inverse = {intc_clk_request_inverse, trace_clk_request_inverse,
                          debug_clk_request_inverse, shared_clk_request_inverse};

    genvar ch;
    generate
        for (ch = 0; ch < `CCQ_NUM_CH; ch = ch + 1) begin : g_channel
            reg [2:0] state;
            reg [2:0] next_state;
            wire req_on;
            wire req_off;
            wire ok;
            reg fault_bit;
            wire stopping;
            wire refusing;

            assign ok = pair_ok(req_low[ch], req_inverse[ch]);
            assign req_on = ok & ~req_low[ch];
            assign req_off = pair_ok(req_low[ch], req_inverse[ch]) & req_low[ch];

            always @* begin
                next_state = state;
                case (state)
                    `CCQ_ST_RUN: begin
                        // Refuse while the cluster still needs the clock
                        if (req_on) begin
                            next_state = busy[ch] ? `CCQ_ST_REFUSED : `CCQ_ST_STOPPED;
                        end
                    end
                    `CCQ_ST_STOPPED: begin
                        if (req_off) begin
                            next_state = `CCQ_ST_RUN;
                        end
                    end
                    `CCQ_ST_REFUSED: begin
                        if (req_off) begin
                            next_state = `CCQ_ST_RUN;
                        end
                    end
                    default: begin
                        next_state = `CCQ_ST_RUN;
                    end
                endcase
            end

            // A mismatched pair freezes the channel rather than guessing a level
            always @(posedge clock) begin
                if (reset) begin
                    state <= `CCQ_ST_RUN;
                end else begin
                    state <= next_state;
                end
            end

            always @(posedge clock) begin
                if (reset) begin
                    fault_bit <= 1'h0;
                end else begin
                    fault_bit <= ~ok;
                end
            end
            assign fault[ch] = fault_bit;

            assign stopping = in_state(next_state, `CCQ_ST_STOPPED);
            assign refusing = in_state(next_state, `CCQ_ST_REFUSED);
            assign next_resp[`CCQ_F_NEEDED + ch] = busy[ch];
            assign next_resp[`CCQ_F_ACCEPT + ch] = ~stopping;
            // Trace refuse stays low-active; clear its mask bit if that polarity
            // turns out to be a misprint, the rest of the channel is unaffected
            assign next_resp[`CCQ_F_REFUSE + ch] = refuse_pin(refusing, REFUSE_LOW_MASK[ch]);
        end
    endgenerate

    ccq_dual_rail #(
        .WIDTH(`CCQ_RESP_W),
        .RESET_VALUE({REFUSE_LOW_MASK, `CCQ_RST_ACCEPT_LOW, `CCQ_RST_NEEDED})
    ) u_resp (
        .clock(clock),
        .reset(reset),
        .next_value(next_resp),
        .value(resp),
        .value_inverse(resp_inverse)
    );

    // Each pin and its twin come from separate flops inside u_resp
    assign shared_clk_needed = resp[`CCQ_F_NEEDED + `CCQ_CH_SHARED];
    assign shared_clk_needed_inverse = resp_inverse[`CCQ_F_NEEDED + `CCQ_CH_SHARED];
    assign shared_clk_gate_accept_low = resp[`CCQ_F_ACCEPT + `CCQ_CH_SHARED];
    assign shared_clk_accept_inverse = resp_inverse[`CCQ_F_ACCEPT + `CCQ_CH_SHARED];
    assign shared_clk_gate_refuse = resp[`CCQ_F_REFUSE + `CCQ_CH_SHARED];
    assign shared_clk_refuse_inverse = resp_inverse[`CCQ_F_REFUSE + `CCQ_CH_SHARED];

    assign debug_clk_needed = resp[`CCQ_F_NEEDED + `CCQ_CH_DEBUG];
    assign debug_clk_needed_inverse = resp_inverse[`CCQ_F_NEEDED + `CCQ_CH_DEBUG];
    assign debug_clk_gate_accept_low = resp[`CCQ_F_ACCEPT + `CCQ_CH_DEBUG];
    assign debug_clk_accept_inverse = resp_inverse[`CCQ_F_ACCEPT + `CCQ_CH_DEBUG];
    assign debug_clk_gate_refuse = resp[`CCQ_F_REFUSE + `CCQ_CH_DEBUG];
    assign debug_clk_refuse_inverse = resp_inverse[`CCQ_F_REFUSE + `CCQ_CH_DEBUG];

    assign trace_clk_needed = resp[`CCQ_F_NEEDED + `CCQ_CH_TRACE];
    assign trace_clk_needed_inverse = resp_inverse[`CCQ_F_NEEDED + `CCQ_CH_TRACE];
    assign trace_clk_gate_accept_low = resp[`CCQ_F_ACCEPT + `CCQ_CH_TRACE];
    assign trace_clk_accept_inverse = resp_inverse[`CCQ_F_ACCEPT + `CCQ_CH_TRACE];
    assign trace_clk_gate_refuse = resp[`CCQ_F_REFUSE + `CCQ_CH_TRACE];
    assign trace_clk_refuse_inverse = resp_inverse[`CCQ_F_REFUSE + `CCQ_CH_TRACE];

    assign intc_clk_needed = resp[`CCQ_F_NEEDED + `CCQ_CH_INTC];
    assign intc_clk_needed_inverse = resp_inverse[`CCQ_F_NEEDED + `CCQ_CH_INTC];
    assign intc_clk_gate_accept_low = resp[`CCQ_F_ACCEPT + `CCQ_CH_INTC];
    assign intc_clk_accept_inverse = resp_inverse[`CCQ_F_ACCEPT + `CCQ_CH_INTC];
    assign intc_clk_gate_refuse = resp[`CCQ_F_REFUSE + `CCQ_CH_INTC];
    assign intc_clk_refuse_inverse = resp_inverse[`CCQ_F_REFUSE + `CCQ_CH_INTC];

    assign shared_clk_check_fault = fault[`CCQ_CH_SHARED];
    assign debug_clk_check_fault = fault[`CCQ_CH_DEBUG];
    assign trace_clk_check_fault = fault[`CCQ_CH_TRACE];
    assign intc_clk_check_fault = fault[`CCQ_CH_INTC];

endmodule // ccq_top

// [test/ccq_chk_sva.sv]
// Checker for the shared clock quiesce channel
`timescale 1ns/1ns
module ccq_chk (
    input wire clock,
    input wire reset,
    input wire shared_clk_busy,
    input wire shared_clk_needed,
    input wire shared_clk_needed_inverse,
    input wire shared_clk_gate_request_low,
    input wire shared_clk_request_inverse,
    input wire shared_clk_gate_accept_low,
    input wire shared_clk_accept_inverse,
    input wire shared_clk_gate_refuse,
    input wire shared_clk_refuse_inverse
);
    wire rq = !shared_clk_gate_request_low && shared_clk_request_inverse;
    wire rel = shared_clk_gate_request_low && !shared_clk_request_inverse;
    wire idle = shared_clk_gate_accept_low && !shared_clk_gate_refuse;
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    a_need_follow: assert property ($changed(shared_clk_busy)
        |=> shared_clk_needed == $past(shared_clk_busy)) else $error("needed wrong");
    a_accept_take: assert property (rq && idle && !shared_clk_busy
        |=> !shared_clk_gate_accept_low && !shared_clk_gate_refuse) else $error("no accept");
    a_refuse_take: assert property (rq && idle && shared_clk_busy
        |=> shared_clk_gate_refuse && shared_clk_gate_accept_low) else $error("no refuse");
    a_resp_hold: assert property (rq && !idle |=> !idle) else $error("response dropped");
    a_resp_cause: assert property ($fell(idle) |-> $past(rq)) else $error("unasked response");
    a_resp_release: assert property (rel && !idle |=> idle) else $error("response stuck");
    a_twin_need: assert property (shared_clk_needed_inverse != shared_clk_needed) else $error("needed twin");
    a_twin_resp: assert property (shared_clk_accept_inverse != shared_clk_gate_accept_low
        && shared_clk_refuse_inverse != shared_clk_gate_refuse) else $error("response twin");
    a_pair_freeze: assert property (shared_clk_gate_request_low == shared_clk_request_inverse
        |=> $stable({shared_clk_gate_accept_low, shared_clk_gate_refuse})) else $error("bad pair taken");
    c_accept: cover property (rq && idle && !shared_clk_busy);
    c_refuse: cover property (rq && idle && shared_clk_busy);
    c_bad_pair: cover property (shared_clk_gate_request_low == shared_clk_request_inverse);
endmodule // ccq_chk
bind ccq_top ccq_chk u_chk (.*);

// [test/ccq_ctrl_model.sv]
// Clock controller model: one request pair per domain
`timescale 1ns/1ns
module ccq_ctrl_model (
    input wire clock,
    input wire [3:0] go,
    input wire [3:0] bad,
    output reg [3:0] req_low,
    output reg [3:0] req_inverse
);
    initial req_low = 4'hF;
    initial req_inverse = 4'h0;
    // Bench holds go until it has seen the answer, so the clock is only gated while accepted
    always @(posedge clock) begin
        req_low <= ~go;
        req_inverse <= go ^ bad;
    end
endmodule // ccq_ctrl_model

// [test/testbench.sv]
// Self-checking bench for the four-domain quiesce handshake
`timescale 1ns/1ns
module testbench;
    reg clock = 1'b0;
    reg reset = 1'b1;
    reg [3:0] busy = 4'h0, go = 4'h0, bad = 4'h0;
    wire [3:0] rq, rq_n, need, need_n, acc, acc_n, rf, rf_n, flt;
    int fail_count = 0;
    int tests_run = 0;
    always #20 clock = ~clock;
    ccq_ctrl_model u_ctrl (.clock(clock), .go(go), .bad(bad), .req_low(rq), .req_inverse(rq_n));
    ccq_top u_dut (.clock(clock), .reset(reset),
        .shared_clk_busy(busy[0]), .shared_clk_needed(need[0]), .shared_clk_needed_inverse(need_n[0]),
        .shared_clk_gate_request_low(rq[0]), .shared_clk_request_inverse(rq_n[0]),
        .shared_clk_gate_accept_low(acc[0]), .shared_clk_accept_inverse(acc_n[0]),
        .shared_clk_gate_refuse(rf[0]), .shared_clk_refuse_inverse(rf_n[0]), .shared_clk_check_fault(flt[0]),
        .debug_clk_busy(busy[1]), .debug_clk_needed(need[1]), .debug_clk_needed_inverse(need_n[1]),
        .debug_clk_gate_request_low(rq[1]), .debug_clk_request_inverse(rq_n[1]),
        .debug_clk_gate_accept_low(acc[1]), .debug_clk_accept_inverse(acc_n[1]),
        .debug_clk_gate_refuse(rf[1]), .debug_clk_refuse_inverse(rf_n[1]), .debug_clk_check_fault(flt[1]),
        .trace_clk_busy(busy[2]), .trace_clk_needed(need[2]), .trace_clk_needed_inverse(need_n[2]),
        .trace_clk_gate_request_low(rq[2]), .trace_clk_request_inverse(rq_n[2]),
        .trace_clk_gate_accept_low(acc[2]), .trace_clk_accept_inverse(acc_n[2]),
        .trace_clk_gate_refuse(rf[2]), .trace_clk_refuse_inverse(rf_n[2]), .trace_clk_check_fault(flt[2]),
        .intc_clk_busy(busy[3]), .intc_clk_needed(need[3]), .intc_clk_needed_inverse(need_n[3]),
        .intc_clk_gate_request_low(rq[3]), .intc_clk_request_inverse(rq_n[3]),
        .intc_clk_gate_accept_low(acc[3]), .intc_clk_accept_inverse(acc_n[3]),
        .intc_clk_gate_refuse(rf[3]), .intc_clk_refuse_inverse(rf_n[3]), .intc_clk_check_fault(flt[3]));
    task report_and_stop;
        if (fail_count == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task chk(input string nm, input logic [3:0] e, input logic [3:0] g);
        tests_run++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", nm, e, g);
            fail_count++;
        end
    endtask
    // Sampling at the falling edge keeps checks clear of the design's own updates
    task cyc(input int n);
        repeat (n) @(posedge clock);
    endtask
    task t_resp(input logic [3:0] a, input logic [3:0] r);
        @(negedge clock);
        chk("accept", a, acc);
        chk("refuse", r, rf);
        chk("accept_inv", ~a, acc_n);
        chk("refuse_inv", ~r, rf_n);
    endtask
    task t_need;
        cyc(1);
        busy <= 4'hF;
        cyc(2);
        @(negedge clock);
        chk("needed", 4'hF, need);
        chk("needed_inv", 4'h0, need_n);
        cyc(1);
        busy <= 4'h0;
        cyc(2);
        @(negedge clock);
        chk("needed", 4'h0, need);
        chk("needed_inv", 4'hF, need_n);
    endtask
    // Refused on busy, else accepted; busy flips mid-response and must not end it
    task t_hs(input int c, input bit b);
        logic [3:0] a, r;
        a = b ? 4'hF : 4'hF ^ (4'h1 << c);
        r = b ? 4'h4 ^ (4'h1 << c) : 4'h4;
        cyc(1);
        busy[c] <= b;
        go[c] <= 1'b1;
        cyc(4);
        t_resp(a, r);
        cyc(1);
        busy[c] <= ~b;
        cyc(3);
        t_resp(a, r);
        cyc(1);
        go[c] <= 1'b0;
        busy[c] <= 1'b0;
        cyc(3);
        t_resp(4'hF, 4'h4);
    endtask
    // A broken request pair is ignored and flagged, then the mended pair is taken
    task t_fault(input int c);
        cyc(1);
        go[c] <= 1'b1;
        bad[c] <= 1'b1;
        cyc(4);
        @(negedge clock);
        chk("fault", 4'h1 << c, flt);
        t_resp(4'hF, 4'h4);
        cyc(1);
        bad[c] <= 1'b0;
        cyc(4);
        t_resp(4'hF ^ (4'h1 << c), 4'h4);
        chk("fault", 4'h0, flt);
        cyc(1);
        go[c] <= 1'b0;
        cyc(4);
    endtask
    // Reset in mid-handshake idles every pin; a request still low is taken again after release
    task t_reset;
        cyc(1);
        busy <= 4'h4;
        go <= 4'h5;
        cyc(4);
        t_resp(4'hE, 4'h0);
        cyc(1);
        reset <= 1'b1;
        cyc(2);
        t_resp(4'hF, 4'h4);
        chk("needed", 4'h0, need);
        cyc(1);
        reset <= 1'b0;
        cyc(2);
        t_resp(4'hE, 4'h0);
        cyc(1);
        go <= 4'h0;
        busy <= 4'h0;
        cyc(4);
        t_resp(4'hF, 4'h4);
    endtask
    initial begin
        #400000;
        fail_count++;
        report_and_stop;
    end
    initial begin
        cyc(20);
        reset <= 1'b0;
        t_resp(4'hF, 4'h4);
        t_need;
        for (int c = 0; c < 4; c++) begin
            t_hs(c, 1'b0);
            t_hs(c, 1'b1);
        end
        t_fault(0);
        t_fault(2);
        t_reset;
        report_and_stop;
    end
endmodule // testbench
